// ---- bench/flash_prog_checker.sv ----
// Protocol checks on the flash programming link
`timescale 1ns/1ps
`default_nettype none
module flash_prog_checker (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic command_strobe_n,
    input wire logic ready,
    input wire logic read_output_enable_n,
    input wire logic read_data_valid_n,
    input wire logic prog_data_oe,
    input wire logic dev_data_oe
);
    // ------------------------------
    // Handshake properties
    // ------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence oe_drop; $fell(read_output_enable_n); endsequence
    sequence word_shown; ##[1:4] !read_data_valid_n; endsequence
    sequence word_held; !read_data_valid_n && !read_output_enable_n; endsequence
    start_when_ready_a: assert property ($fell(command_strobe_n) |-> $past(ready))
        else $error("strobe fell while busy");
    capture_drops_a: assert property (ready && !command_strobe_n |=> !ready)
        else $error("ready stayed high after capture");
    ready_after_strobe_a: assert property ($rose(ready) |-> $past(command_strobe_n))
        else $error("ready rose with strobe low");
    finish_bound_a: assert property ($rose(command_strobe_n) |-> ##[1:16] ready)
        else $error("ready did not return");
    drive_on_oe_a: assert property ($rose(dev_data_oe) |-> !read_output_enable_n)
        else $error("bus driven without output enable");
    no_fight_a: assert property (!(dev_data_oe && prog_data_oe))
        else $error("both ends drive the bus");
    word_shown_a: assert property (oe_drop |-> word_shown)
        else $error("data valid not lowered");
    valid_after_drive_a: assert property ($fell(read_data_valid_n) |-> dev_data_oe)
        else $error("data valid low with bus not driven");
    release_first_a: assert property ($rose(read_data_valid_n) |-> !dev_data_oe)
        else $error("data valid rose with bus driven");
    valid_waits_oe_a: assert property (word_held |=> !read_data_valid_n)
        else $error("data valid rose before output enable");
endmodule
`default_nettype wire

// ---- bench/flash_prog_handshake_read_tb_top.sv ----
// Random and corner tests of the flash read handshake
`timescale 1ns/1ps
`default_nettype none
module flash_prog_handshake_read_tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_read = 1'b0;
    logic        rd_ready = 1'b0;
    logic        mem_write = 1'b0;
    logic [3:0]  req_mode = 4'h0;
    logic [15:0] req_data = 16'h0000;
    logic [9:0]  mem_addr = 10'h000;
    logic [15:0] mem_wdata = 16'h0000;
    logic [15:0] mem_model [0:1023];
    logic        req_ready, rd_valid, sel_ext, pending;
    logic [15:0] rd_data, command;
    int          fail_count = 0;
    int          check_count = 0;
    int          base;
    flash_prog_if link ();
    flash_prog_device #(.MEM_AW(10)) flash_prog_device_inst (.CLK(clk), .RESETN(resetn),
        .LINK(link), .MEM_WRITE(mem_write), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
        .CLOCK_SEL_EXT(sel_ext), .COMMAND(command), .PENDING(pending));
    flash_prog_programmer #(.POR_WAIT_CYCLES(4), .EXT_CLK_HALF(100)) flash_prog_programmer_inst (
        .CLK(clk), .RESETN(resetn), .LINK(link), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_MODE(req_mode), .REQ_DATA(req_data), .REQ_READ(req_read), .RD_VALID(rd_valid),
        .RD_READY(rd_ready), .RD_DATA(rd_data));
    flash_prog_checker flash_prog_checker_inst (.CLK(clk), .RESETN(resetn),
        .command_strobe_n(link.command_strobe_n), .ready(link.ready),
        .read_output_enable_n(link.read_output_enable_n),
        .read_data_valid_n(link.read_data_valid_n), .prog_data_oe(link.prog_data_oe),
        .dev_data_oe(link.dev_data_oe));
    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [15:0] exp_word(input int a);
        return mem_model[a];
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Request is raised only once ready is settled, so the take edge is known
    task automatic send(input logic [3:0] m, input logic [15:0] d, input logic r);
        int n;
        n = 0;
        @(negedge clk);
        req_mode = m;
        req_data = d;
        req_read = r;
        do @(negedge clk); while (req_ready !== 1'b1 && ++n < 3000);
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        req_read = 1'b0;
        // Third edge after the take: strobe seen low, device busy
        repeat (3) @(negedge clk);
        chk(16'(link.ready), 16'h0000);
        while (req_ready !== 1'b1 && ++n < 3000) @(negedge clk);
        chk(16'(link.ready), 16'h0001);
    endtask
    task automatic drain(input int a, input int k);
        for (int i = 0; i < k; i++) begin
            @(negedge clk);
            chk(16'(rd_valid), 16'h0001);
            chk(rd_data, exp_word(a + i));
            rd_ready = 1'b1;
            @(negedge clk);
            rd_ready = 1'b0;
        end
        chk(16'(rd_valid), 16'h0000);
    endtask
    // ------------------------------
    // Sequence
    // ------------------------------
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out;
    end
    initial begin
        void'($urandom(77));
        repeat (16) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 1024; i++) begin
            @(negedge clk);
            mem_write = 1'b1;
            mem_addr = i[9:0];
            mem_wdata = 16'($urandom);
            mem_model[i] = mem_wdata;
        end
        @(negedge clk);
        mem_write = 1'b0;
        // Give the external clock detector time to see two edges
        repeat (600) @(negedge clk);
        send(flash_prog_pkg::MODE_COMMAND, flash_prog_pkg::CMD_READ, 1'b0);
        chk(command, flash_prog_pkg::CMD_READ);
        chk(16'(sel_ext), 16'h0001);
        base = $urandom_range(0, 1000);
        send(flash_prog_pkg::MODE_ADDR_LOW, base[15:0], 1'b0);
        send(flash_prog_pkg::MODE_ADDR_ONE, 16'h0000, 1'b0);
        repeat (4) send(flash_prog_pkg::MODE_DATA, 16'($urandom), 1'b1);
        @(negedge clk);
        req_read = 1'b1;
        @(negedge clk);
        chk(16'(req_ready), 16'h0000);
        req_read = 1'b0;
        drain(base, 4);
        base = $urandom_range(0, 1000);
        send(flash_prog_pkg::MODE_ADDR_LOW, base[15:0], 1'b0);
        repeat (2) send(flash_prog_pkg::MODE_DATA, 16'($urandom), 1'b1);
        drain(base, 2);
        send(4'h6, 16'h0012, 1'b0);
        chk(command, flash_prog_pkg::CMD_READ);
        send(flash_prog_pkg::MODE_COMMAND, 16'h0012, 1'b0);
        send(flash_prog_pkg::MODE_DATA, 16'($urandom), 1'b0);
        chk(16'(pending), 16'h0001);
        send(flash_prog_pkg::MODE_COMMAND, flash_prog_pkg::CMD_READ, 1'b0);
        chk(16'(pending), 16'h0000);
        // Mid-run reset: clock choice is redone before any external edge
        @(negedge clk);
        resetn = 1'b0;
        @(negedge clk);
        chk(16'(link.ready), 16'h0001);
        chk(16'(sel_ext), 16'h0000);
        repeat (15) @(negedge clk);
        resetn = 1'b1;
        send(flash_prog_pkg::MODE_COMMAND, flash_prog_pkg::CMD_READ, 1'b0);
        chk(16'(sel_ext), 16'h0000);
        chk(command, flash_prog_pkg::CMD_READ);
        close_out;
    end
endmodule
`default_nettype wire

// ---- design/flash_prog_device.sv ----
// Device end of the parallel flash programming handshake
`timescale 1ns/1ps
`default_nettype none
module flash_prog_device #(
    parameter int DATA_W       = flash_prog_pkg::DATA_W,
    parameter int MEM_AW       = 10,
    parameter int FLUSH_CYCLES = flash_prog_pkg::FLUSH_CYCLES
) (
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    flash_prog_if.device              LINK,
    input  wire logic                 MEM_WRITE,
    input  wire logic [MEM_AW-1:0]    MEM_ADDR,
    input  wire logic [DATA_W-1:0]    MEM_WDATA,
    output logic                      CLOCK_SEL_EXT,
    output logic [DATA_W-1:0]         COMMAND,
    output logic                      PENDING
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        flash_prog_pkg::dev_state_type      st;
        logic                               ready;
        logic                               valid_n;
        logic                               data_oe;
        logic [DATA_W-1:0]                  data_out;
        logic [3:0]                         mode;
        logic [DATA_W-1:0]                  data;
        logic [DATA_W-1:0]                  cmd;
        logic [flash_prog_pkg::ADDR_W-1:0]  addr;
        logic                               pending;
        logic [7:0]                         flush_cnt;
        logic                               ext_prev;
        logic [flash_prog_pkg::EXT_GAP_W-1:0] ext_gap;
        logic                               ext_seen;
        logic                               ext_present;
        logic                               clk_sel;
        logic                               clk_locked;
    } dev_regs_type;

    localparam logic [flash_prog_pkg::EXT_GAP_W-1:0] EXT_WINDOW =
        flash_prog_pkg::EXT_GAP_W'(flash_prog_pkg::EXT_WINDOW_CYCLES);
    localparam logic [7:0] FLUSH_LAST = 8'(FLUSH_CYCLES - 1);
    localparam logic [DATA_W-1:0] READ_CODE = flash_prog_pkg::CMD_READ[DATA_W-1:0];

    dev_regs_type         st_r;
    dev_regs_type         st_nxt;
    logic [DATA_W-1:0]    flash_mem [0:(1<<MEM_AW)-1];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Each address handshake fills one bus-wide slice, least significant first; a slice past bit 31 of the address changes nothing
    function automatic logic [31:0] addr_insert(
        input logic [31:0]       old,
        input logic [3:0]        sel,
        input logic [DATA_W-1:0] val
    );
        logic [63:0] mask;
        logic [63:0] ins;
        int          pos;
        pos  = (int'(sel) - 1) * DATA_W;
        mask = {{(64-DATA_W){1'b0}}, {DATA_W{1'b1}}} << pos;
        ins  = {{(64-DATA_W){1'b0}}, val} << pos;
        addr_insert = (old & ~mask[31:0]) | ins[31:0];
    endfunction

    // ------------------------------------------------------------
    // Flash array, filled from the user side
    // ------------------------------------------------------------
    // Programming commands are not handled here, so contents come in by this port
    always_ff @(posedge CLK) begin
        if (MEM_WRITE) begin
            flash_mem[MEM_ADDR] <= MEM_WDATA;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic ext_rise;
        ext_rise = 1'b0;
        st_nxt   = st_r;

        // External clock watch: two rising edges closer than the window
        ext_rise        = LINK.external_clock_input & ~st_r.ext_prev;
        st_nxt.ext_prev = LINK.external_clock_input;
        if (ext_rise) begin
            st_nxt.ext_present = st_r.ext_seen && (st_r.ext_gap < EXT_WINDOW);
            st_nxt.ext_seen    = 1'b1;
            st_nxt.ext_gap     = '0;
        end else if (st_r.ext_gap >= EXT_WINDOW) begin
            st_nxt.ext_present = 1'b0;
            st_nxt.ext_seen    = 1'b0;
        end else begin
            st_nxt.ext_gap = st_r.ext_gap + 1'b1;
        end

        case (st_r.st)
            flash_prog_pkg::D_IDLE: begin
                if (!LINK.command_strobe_n) begin
                    st_nxt.mode  = LINK.mode_field;
                    st_nxt.data  = LINK.data_bus;
                    st_nxt.ready = 1'b0;
                    st_nxt.st    = flash_prog_pkg::D_EXEC;
                    if (!st_r.clk_locked) begin
                        // Clock choice is frozen at the first busy period
                        st_nxt.clk_sel    = st_r.ext_present;
                        st_nxt.clk_locked = 1'b1;
                    end
                end
            end
            flash_prog_pkg::D_EXEC: begin
                st_nxt.st = flash_prog_pkg::D_DONE;
                if (st_r.mode == flash_prog_pkg::MODE_COMMAND) begin
                    st_nxt.cmd = st_r.data;
                    if (st_r.pending) begin
                        st_nxt.flush_cnt = FLUSH_LAST;
                        st_nxt.st        = flash_prog_pkg::D_FLUSH;
                    end
                end else if (st_r.mode >= flash_prog_pkg::MODE_ADDR_LOW &&
                             st_r.mode <= flash_prog_pkg::MODE_ADDR_HIGH) begin
                    st_nxt.addr = addr_insert(st_r.addr, st_r.mode, st_r.data);
                end else if (st_r.mode == flash_prog_pkg::MODE_DATA) begin
                    if (st_r.cmd == READ_CODE) begin
                        st_nxt.st = flash_prog_pkg::D_OE_WAIT;
                    end else begin
                        // Data for other commands is not stored; it only sets the pending flag
                        st_nxt.pending = 1'b1;
                    end
                end
                // Any other mode code selects nothing
            end
            flash_prog_pkg::D_FLUSH: begin
                if (st_r.flush_cnt == 8'h00) begin
                    st_nxt.pending = 1'b0;
                    st_nxt.st      = flash_prog_pkg::D_DONE;
                end else begin
                    st_nxt.flush_cnt = st_r.flush_cnt - 8'h01;
                end
            end
            flash_prog_pkg::D_OE_WAIT: begin
                if (!LINK.read_output_enable_n) begin
                    st_nxt.data_oe  = 1'b1;
                    st_nxt.data_out = flash_mem[st_r.addr[MEM_AW-1:0]];
                    st_nxt.st       = flash_prog_pkg::D_DRIVE;
                end
            end
            flash_prog_pkg::D_DRIVE: begin
                // Data already stands a cycle when valid drops
                st_nxt.valid_n = 1'b0;
                st_nxt.st      = flash_prog_pkg::D_OE_HIGH;
            end
            flash_prog_pkg::D_OE_HIGH: begin
                if (LINK.read_output_enable_n) begin
                    st_nxt.data_oe = 1'b0;
                    st_nxt.addr    = st_r.addr + 32'h1;
                    st_nxt.st      = flash_prog_pkg::D_RELEASE;
                end
            end
            flash_prog_pkg::D_RELEASE: begin
                // Bus is released a full cycle before valid rises
                st_nxt.valid_n = 1'b1;
                st_nxt.st      = flash_prog_pkg::D_DONE;
            end
            flash_prog_pkg::D_DONE: begin
                if (LINK.command_strobe_n) begin
                    st_nxt.ready = 1'b1;
                    st_nxt.st    = flash_prog_pkg::D_IDLE;
                end
            end
            default: begin
                st_nxt.st = flash_prog_pkg::D_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r             <= '0;
            st_r.st          <= flash_prog_pkg::D_IDLE;
            st_r.ready       <= 1'b1;
            st_r.valid_n     <= 1'b1;
            st_r.data_oe     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign LINK.ready             = st_r.ready;
    assign LINK.read_data_valid_n = st_r.valid_n;
    assign LINK.dev_data_oe       = st_r.data_oe;
    assign LINK.dev_data_out      = st_r.data_out;
    assign CLOCK_SEL_EXT          = st_r.clk_sel;
    assign COMMAND                = st_r.cmd;
    assign PENDING                = st_r.pending;

endmodule
`default_nettype wire

// ---- design/flash_prog_if.sv ----
// Link between the flash device end and the programmer end
`timescale 1ns/1ps
`default_nettype none
interface flash_prog_if #(
    parameter int DW = flash_prog_pkg::DATA_W
);
    logic           command_strobe_n;
    logic [3:0]     mode_field;
    logic           ready;
    logic           read_output_enable_n;
    logic           read_data_valid_n;
    logic           external_clock_input;
    logic [DW-1:0]  prog_data_out;
    logic           prog_data_oe;
    logic [DW-1:0]  dev_data_out;
    logic           dev_data_oe;
    logic [DW-1:0]  data_bus;

    // Bus level from the enables; undriven lines float high like pull-ups
    assign data_bus = dev_data_oe  ? dev_data_out  :
                      prog_data_oe ? prog_data_out : {DW{1'b1}};

    modport device (
        input  command_strobe_n,
        input  mode_field,
        input  read_output_enable_n,
        input  external_clock_input,
        input  data_bus,
        output ready,
        output read_data_valid_n,
        output dev_data_out,
        output dev_data_oe
    );

    modport programmer (
        output command_strobe_n,
        output mode_field,
        output read_output_enable_n,
        output external_clock_input,
        output prog_data_out,
        output prog_data_oe,
        input  ready,
        input  read_data_valid_n,
        input  data_bus
    );
endinterface
`default_nettype wire

// ---- design/flash_prog_pkg.sv ----
// Shared constants and state encodings for the flash programming port
package flash_prog_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int MODE_W = 4;
    localparam int ADDR_W = 32;

    // ------------------------------------------------------------
    // Mode field codes and commands
    // ------------------------------------------------------------
    localparam logic [3:0]  MODE_COMMAND      = 4'h0;
    localparam logic [3:0]  MODE_ADDR_LOW     = 4'h1;
    localparam logic [3:0]  MODE_ADDR_ONE     = 4'h2;
    localparam logic [3:0]  MODE_ADDR_TWO     = 4'h3;
    localparam logic [3:0]  MODE_ADDR_HIGH    = 4'h4;
    localparam logic [3:0]  MODE_DATA         = 4'h5;
    localparam logic [15:0] CMD_READ          = 16'h0011;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ            = 40_000_000;
    localparam int EXT_MIN_HZ        = 32_000;
    // Longest gap between external clock edges, rounded down
    localparam int EXT_WINDOW_CYCLES = CLK_HZ / EXT_MIN_HZ;
    localparam int EXT_GAP_W         = 11;
    localparam int FLUSH_CYCLES      = 4;
    localparam int POR_WAIT_CYCLES   = 400;
    localparam int FIFO_DEPTH        = 4;

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        D_IDLE      = 8'h01,
        D_EXEC      = 8'h02,
        D_FLUSH     = 8'h04,
        D_OE_WAIT   = 8'h08,
        D_DRIVE     = 8'h10,
        D_OE_HIGH   = 8'h20,
        D_RELEASE   = 8'h40,
        D_DONE      = 8'h80
    } dev_state_type;

    typedef enum logic [7:0] {
        P_POR       = 8'h01,
        P_IDLE      = 8'h02,
        P_SETUP     = 8'h04,
        P_RDY_LOW   = 8'h08,
        P_OE_LOW    = 8'h10,
        P_VLD_LOW   = 8'h20,
        P_VLD_HIGH  = 8'h40,
        P_RDY_HIGH  = 8'h80
    } prog_state_type;

endpackage

// ---- design/flash_prog_programmer.sv ----
// Programmer end of the flash handshake, with its read-data FIFO
`timescale 1ns/1ps
`default_nettype none
module prog_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 4
) (
    input  wire logic           CLK,
    input  wire logic           RESETN,
    input  wire logic           IN_VALID,
    output logic                IN_READY,
    input  wire logic [W-1:0]   IN_DATA,
    output logic                OUT_VALID,
    input  wire logic           OUT_READY,
    output logic [W-1:0]        OUT_DATA
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wr;
        logic [PW-1:0]           rd;
        logic [PW:0]             count;
    } fifo_regs_type;

    fifo_regs_type st_r;
    fifo_regs_type st_nxt;
    logic          push;
    logic          pop;

    assign IN_READY  = (st_r.count != (PW+1)'(DEPTH));
    assign OUT_VALID = (st_r.count != '0);
    assign OUT_DATA  = st_r.mem[st_r.rd];
    assign push      = IN_VALID & IN_READY;
    assign pop       = OUT_VALID & OUT_READY;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = IN_DATA;
            st_nxt.wr = (st_r.wr == PW'(DEPTH-1)) ? '0 : st_r.wr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd = (st_r.rd == PW'(DEPTH-1)) ? '0 : st_r.rd + 1'b1;
        end
        st_nxt.count = st_r.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

module flash_prog_programmer #(
    parameter int DATA_W          = flash_prog_pkg::DATA_W,
    parameter int POR_WAIT_CYCLES = flash_prog_pkg::POR_WAIT_CYCLES,
    parameter int EXT_CLK_HALF    = 0
) (
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    flash_prog_if.programmer          LINK,
    input  wire logic                 REQ_VALID,
    output logic                      REQ_READY,
    input  wire logic [3:0]           REQ_MODE,
    input  wire logic [DATA_W-1:0]    REQ_DATA,
    input  wire logic                 REQ_READ,
    output logic                      RD_VALID,
    input  wire logic                 RD_READY,
    output logic [DATA_W-1:0]         RD_DATA
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        flash_prog_pkg::prog_state_type st;
        logic [15:0]                    por_cnt;
        logic                           strobe_n;
        logic [3:0]                     mode;
        logic [DATA_W-1:0]              data;
        logic                           data_oe;
        logic                           oe_n;
        logic                           is_read;
        logic [15:0]                    ext_cnt;
        logic                           ext_lvl;
    } prog_regs_type;

    prog_regs_type st_r;
    prog_regs_type st_nxt;
    logic          fifo_in_valid;
    logic          fifo_in_ready;

    // A read is only started with room for its word, so the push never stalls
    assign REQ_READY = (st_r.st == flash_prog_pkg::P_IDLE) && LINK.ready &&
                       (!REQ_READ || fifo_in_ready);
    assign fifo_in_valid = (st_r.st == flash_prog_pkg::P_VLD_LOW) &&
                           !LINK.read_data_valid_n;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Optional external clock from a divider, low when disabled
        if (EXT_CLK_HALF > 0) begin
            if (st_r.ext_cnt == 16'(EXT_CLK_HALF - 1)) begin
                st_nxt.ext_cnt = '0;
                st_nxt.ext_lvl = ~st_r.ext_lvl;
            end else begin
                st_nxt.ext_cnt = st_r.ext_cnt + 16'h1;
            end
        end
        case (st_r.st)
            flash_prog_pkg::P_POR: begin
                if (st_r.por_cnt == 16'h0) begin
                    st_nxt.st = flash_prog_pkg::P_IDLE;
                end else begin
                    st_nxt.por_cnt = st_r.por_cnt - 16'h1;
                end
            end
            flash_prog_pkg::P_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    st_nxt.mode    = REQ_MODE;
                    st_nxt.data    = REQ_DATA;
                    st_nxt.data_oe = 1'b1;
                    st_nxt.is_read = REQ_READ;
                    st_nxt.st      = flash_prog_pkg::P_SETUP;
                end
            end
            flash_prog_pkg::P_SETUP: begin
                st_nxt.strobe_n = 1'b0;
                st_nxt.st       = flash_prog_pkg::P_RDY_LOW;
            end
            flash_prog_pkg::P_RDY_LOW: begin
                if (!LINK.ready) begin
                    st_nxt.data_oe = 1'b0;
                    if (st_r.is_read) begin
                        st_nxt.st = flash_prog_pkg::P_OE_LOW;
                    end else begin
                        st_nxt.strobe_n = 1'b1;
                        st_nxt.st       = flash_prog_pkg::P_RDY_HIGH;
                    end
                end
            end
            flash_prog_pkg::P_OE_LOW: begin
                st_nxt.oe_n = 1'b0;
                st_nxt.st   = flash_prog_pkg::P_VLD_LOW;
            end
            flash_prog_pkg::P_VLD_LOW: begin
                if (!LINK.read_data_valid_n) begin
                    st_nxt.oe_n = 1'b1;
                    st_nxt.st   = flash_prog_pkg::P_VLD_HIGH;
                end
            end
            flash_prog_pkg::P_VLD_HIGH: begin
                if (LINK.read_data_valid_n) begin
                    st_nxt.data_oe  = 1'b1;
                    st_nxt.strobe_n = 1'b1;
                    st_nxt.st       = flash_prog_pkg::P_RDY_HIGH;
                end
            end
            flash_prog_pkg::P_RDY_HIGH: begin
                if (LINK.ready) begin
                    st_nxt.data_oe = 1'b0;
                    st_nxt.st      = flash_prog_pkg::P_IDLE;
                end
            end
            default: begin
                st_nxt.st = flash_prog_pkg::P_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r          <= '0;
            st_r.st       <= flash_prog_pkg::P_POR;
            st_r.por_cnt  <= 16'(POR_WAIT_CYCLES);
            st_r.strobe_n <= 1'b1;
            st_r.oe_n     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data buffer and outputs
    // ------------------------------------------------------------
    prog_fifo #(
        .W     (DATA_W),
        .DEPTH (flash_prog_pkg::FIFO_DEPTH)
    ) u_fifo (
        .CLK       (CLK),
        .RESETN    (RESETN),
        .IN_VALID  (fifo_in_valid),
        .IN_READY  (fifo_in_ready),
        .IN_DATA   (LINK.data_bus),
        .OUT_VALID (RD_VALID),
        .OUT_READY (RD_READY),
        .OUT_DATA  (RD_DATA)
    );

    assign LINK.command_strobe_n     = st_r.strobe_n;
    assign LINK.mode_field           = st_r.mode;
    assign LINK.prog_data_out        = st_r.data;
    assign LINK.prog_data_oe         = st_r.data_oe;
    assign LINK.read_output_enable_n = st_r.oe_n;
    assign LINK.external_clock_input = st_r.ext_lvl;

endmodule
`default_nettype wire
